// ==== hw/dpg_gpio.sv ====
// Dual 8-bit GPIO with wake-up and pin 0 interrupt requests
// Summary of operation
// - Direction bit 0 input, 1 output
// - Pull-high bit enables internal pull-up
// - Port A pin 5 has no pull-up
// - Data latch per port, read/write, reset zero
// - Port A 7,6,4,3 enable gates input and wake
// - Port A 5,2,1 enable gates wake only
// - Port A bit 0 gates input, wake and interrupt
// - Port B 7,3,2,1,0 gate input and wake
// - Port B 6,5,4 enable gates wake only
// - Edge select: both, rise, fall, reserved
// - Output mode reads latch, input reads pad
// - Pull-up off while driving low
// - Port A pin 5 open-drain in output
// - Enabled input pin change raises wake request in sleep mode only
`timescale 1ns/100ps
`default_nettype none
module dpg_gpio
  import dpg_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire dpg_io_req_type    io_req,
  output logic [7:0]             io_rdata,
  input  wire logic              sleep_mode,
  input  wire logic [7:0]        port_a_pad_in,
  input  wire logic [7:0]        port_b_pad_in,
  output var dpg_pad_drive_type  port_a_pad,
  output var dpg_pad_drive_type  port_b_pad,
  output logic                   wake_req,
  output logic                   port_a_pin0_irq,
  output logic                   port_b_pin0_irq
);
  logic [7:0] a_data_r, a_dir_r, a_pull_r, a_inen_r, b_data_r, b_dir_r, b_pull_r, b_inen_r, edge_r, rdata_r;
  logic [7:0] a_data_nxt, a_dir_nxt, a_pull_nxt, a_inen_nxt, b_data_nxt, b_dir_nxt, b_pull_nxt, b_inen_nxt;
  logic [7:0] edge_nxt, rdata_nxt;
  logic       a_irq_r, b_irq_r, a_irq_nxt, b_irq_nxt;
  logic [7:0] a_read, b_read, a_lvl, b_lvl, a_prev, b_prev;
  logic       a_chg, b_chg;

  dpg_port #(.INPUT_GATED(DPG_A_INPUT_GATED), .HAS_PULL(DPG_A_HAS_PULL), .OPEN_DRAIN(DPG_A_OPEN_DRAIN)) u_port_a (
    .clk(clk), .arst_n(arst_n), .data_r_in(a_data_r), .dir_r_in(a_dir_r), .pull_r_in(a_pull_r),
    .inen_r_in(a_inen_r), .pad_in(port_a_pad_in), .pad_drv(port_a_pad), .read_val(a_read),
    .pin_level(a_lvl), .pin_prev(a_prev), .wake_change(a_chg)
  );

  dpg_port #(.INPUT_GATED(DPG_B_INPUT_GATED), .HAS_PULL(DPG_ALL), .OPEN_DRAIN(DPG_NONE)) u_port_b (
    .clk(clk), .arst_n(arst_n), .data_r_in(b_data_r), .dir_r_in(b_dir_r), .pull_r_in(b_pull_r),
    .inen_r_in(b_inen_r), .pad_in(port_b_pad_in), .pad_drv(port_b_pad), .read_val(b_read),
    .pin_level(b_lvl), .pin_prev(b_prev), .wake_change(b_chg)
  );

  function automatic logic edge_hit(input logic [1:0] sel, input logic cur, input logic prv);
    logic rise;
    logic fall;
    rise = cur & ~prv;
    fall = ~cur & prv;
    case (sel)
      DPG_EDGE_BOTH: edge_hit = rise | fall;
      DPG_EDGE_RISE: edge_hit = rise;
      DPG_EDGE_FALL: edge_hit = fall;
      default:       edge_hit = 1'b0;
    endcase
  endfunction : edge_hit

  always_comb begin
    a_data_nxt = a_data_r;
    a_dir_nxt  = a_dir_r;
    a_pull_nxt = a_pull_r;
    a_inen_nxt = a_inen_r;
    b_data_nxt = b_data_r;
    b_dir_nxt  = b_dir_r;
    b_pull_nxt = b_pull_r;
    b_inen_nxt = b_inen_r;
    edge_nxt   = edge_r;
    if (io_req.wr) begin
      case (io_req.addr)
        DPG_OFF_EDGE_SEL: edge_nxt   = io_req.wdata;
        DPG_OFF_A_INEN:   a_inen_nxt = io_req.wdata;
        DPG_OFF_B_INEN:   b_inen_nxt = io_req.wdata;
        DPG_OFF_A_DATA:   a_data_nxt = io_req.wdata;
        DPG_OFF_A_DIR:    a_dir_nxt  = io_req.wdata;
        DPG_OFF_A_PULL:   a_pull_nxt = io_req.wdata;
        DPG_OFF_B_DATA:   b_data_nxt = io_req.wdata;
        DPG_OFF_B_DIR:    b_dir_nxt  = io_req.wdata;
        DPG_OFF_B_PULL:   b_pull_nxt = io_req.wdata;
        default: ;
      endcase
    end
    // Write-only and unmapped offsets read as zero
    case (io_req.addr)
      DPG_OFF_A_DATA: rdata_nxt = a_read;
      DPG_OFF_A_DIR:  rdata_nxt = a_dir_r;
      DPG_OFF_A_PULL: rdata_nxt = a_pull_r;
      DPG_OFF_B_DATA: rdata_nxt = b_read;
      DPG_OFF_B_DIR:  rdata_nxt = b_dir_r;
      DPG_OFF_B_PULL: rdata_nxt = b_pull_r;
      default:        rdata_nxt = DPG_RST_ZERO;
    endcase
    if (!io_req.rd) begin
      rdata_nxt = rdata_r;
    end
    // Pin 0 is input-gated on both ports, so a disabled enable blocks edges
    a_irq_nxt = a_inen_r[0] & ~a_dir_r[0] & edge_hit(edge_r[DPG_EDGE_A_LSB +: 2], a_lvl[0], a_prev[0]);
    b_irq_nxt = b_inen_r[0] & ~b_dir_r[0] & edge_hit(edge_r[DPG_EDGE_B_LSB +: 2], b_lvl[0], b_prev[0]);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      a_data_r <= DPG_RST_ZERO;
      a_dir_r  <= DPG_RST_ZERO;
      a_pull_r <= DPG_RST_ZERO;
      a_inen_r <= DPG_RST_INEN;
      b_data_r <= DPG_RST_ZERO;
      b_dir_r  <= DPG_RST_ZERO;
      b_pull_r <= DPG_RST_ZERO;
      b_inen_r <= DPG_RST_INEN;
      edge_r   <= DPG_RST_ZERO;
      rdata_r  <= DPG_RST_ZERO;
      a_irq_r  <= 1'b0;
      b_irq_r  <= 1'b0;
    end else begin
      a_data_r <= a_data_nxt;
      a_dir_r  <= a_dir_nxt;
      a_pull_r <= a_pull_nxt;
      a_inen_r <= a_inen_nxt;
      b_data_r <= b_data_nxt;
      b_dir_r  <= b_dir_nxt;
      b_pull_r <= b_pull_nxt;
      b_inen_r <= b_inen_nxt;
      edge_r   <= edge_nxt;
      rdata_r  <= rdata_nxt;
      a_irq_r  <= a_irq_nxt;
      b_irq_r  <= b_irq_nxt;
    end
  end

  assign io_rdata        = rdata_r;
  assign port_a_pin0_irq = a_irq_r;
  assign port_b_pin0_irq = b_irq_r;
  assign wake_req        = sleep_mode & (a_chg | b_chg);

  a_dir_write: assert property (@(posedge clk) disable iff (!arst_n)
    io_req.wr && io_req.addr == DPG_OFF_A_DIR |=> a_dir_r == $past(io_req.wdata))
    else $error("direction write lost");
  a_pull_lowdrv: assert property (@(posedge clk) disable iff (!arst_n)
    (a_dir_r[0] && !a_data_r[0]) |-> !port_a_pad.pull[0])
    else $error("pull-up on while driving low");
  a_no_pull5: assert property (@(posedge clk) disable iff (!arst_n) !port_a_pad.pull[5])
    else $error("pull-up on port A pin 5");
  a_open_drain: assert property (@(posedge clk) disable iff (!arst_n)
    port_a_pad.oe[5] |-> !port_a_pad.out[5])
    else $error("pin 5 driving high");
  a_read_out: assert property (@(posedge clk) disable iff (!arst_n)
    io_req.rd && io_req.addr == DPG_OFF_B_DATA && b_dir_r == DPG_ALL |=> io_rdata == $past(b_data_r))
    else $error("output-mode read not from latch");
  a_irq_pulse: assert property (@(posedge clk) disable iff (!arst_n)
    port_a_pin0_irq && edge_r[1:0] != DPG_EDGE_BOTH |=> !port_a_pin0_irq)
    else $error("single-edge irq longer than one cycle");
  a_irq_gate: assert property (@(posedge clk) disable iff (!arst_n)
    !a_inen_r[0] |=> !port_a_pin0_irq)
    else $error("irq while pin 0 disabled");
  a_irq_rise: assert property (@(posedge clk) disable iff (!arst_n)
    port_b_pin0_irq && $past(edge_r[3:2]) == DPG_EDGE_RISE |-> $past(b_lvl[0]))
    else $error("rising select fired on fall");
  a_wake_gate: assert property (@(posedge clk) disable iff (!arst_n)
    !sleep_mode |-> !wake_req)
    else $error("wake while awake");
  a_gate_low: assert property (@(posedge clk) disable iff (!arst_n)
    !a_inen_r[7] |-> !a_lvl[7])
    else $error("disabled input not low");

  c_irq_a: cover property (@(posedge clk) disable iff (!arst_n) port_a_pin0_irq);
  c_irq_b: cover property (@(posedge clk) disable iff (!arst_n) port_b_pin0_irq);
  c_wake: cover property (@(posedge clk) disable iff (!arst_n) wake_req);
  c_od: cover property (@(posedge clk) disable iff (!arst_n) port_a_pad.oe[5]);
endmodule : dpg_gpio
`default_nettype wire

// ==== hw/dpg_pkg.sv ====
// Package for the dual port GPIO block: register offsets, reset values, field positions
package dpg_pkg;
  localparam int         DPG_WIDTH          = 8;
  localparam int         DPG_ADDR_W         = 6;
  localparam logic [5:0] DPG_OFF_EDGE_SEL   = 6'h0c;
  localparam logic [5:0] DPG_OFF_A_INEN     = 6'h0d;
  localparam logic [5:0] DPG_OFF_B_INEN     = 6'h0e;
  localparam logic [5:0] DPG_OFF_A_DATA     = 6'h10;
  localparam logic [5:0] DPG_OFF_A_DIR      = 6'h11;
  localparam logic [5:0] DPG_OFF_A_PULL     = 6'h12;
  localparam logic [5:0] DPG_OFF_B_DATA     = 6'h14;
  localparam logic [5:0] DPG_OFF_B_DIR      = 6'h15;
  localparam logic [5:0] DPG_OFF_B_PULL     = 6'h16;
  localparam logic [7:0] DPG_RST_ZERO       = 8'h00;
  localparam logic [7:0] DPG_RST_INEN       = 8'hff;
  // Pins whose enable bit also gates the digital input path
  localparam logic [7:0] DPG_A_INPUT_GATED  = 8'hd9;
  localparam logic [7:0] DPG_B_INPUT_GATED  = 8'h8f;
  // Pins that have a pull-up device; open-drain pins
  localparam logic [7:0] DPG_A_HAS_PULL     = 8'hdf;
  localparam logic [7:0] DPG_A_OPEN_DRAIN   = 8'h20;
  localparam logic [7:0] DPG_NONE           = 8'h00;
  localparam logic [7:0] DPG_ALL            = 8'hff;
  localparam int         DPG_EDGE_A_LSB     = 0;
  localparam int         DPG_EDGE_B_LSB     = 2;
  localparam int         DPG_SYNC_STAGES    = 2;
  localparam logic [1:0] DPG_EDGE_BOTH      = 2'h0;
  localparam logic [1:0] DPG_EDGE_RISE      = 2'h1;
  localparam logic [1:0] DPG_EDGE_FALL      = 2'h2;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull;
  } dpg_pad_drive_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } dpg_io_req_type;
endpackage : dpg_pkg

// ==== hw/dpg_port.sv ====
// One 8-bit I/O port: pad drive, input path gating, sync, change detection
`timescale 1ns/100ps
`default_nettype none
module dpg_port
  import dpg_pkg::*;
#(
  parameter logic [7:0] INPUT_GATED = DPG_ALL,
  parameter logic [7:0] HAS_PULL    = DPG_ALL,
  parameter logic [7:0] OPEN_DRAIN  = DPG_NONE
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic [7:0]        data_r_in,
  input  wire logic [7:0]        dir_r_in,
  input  wire logic [7:0]        pull_r_in,
  input  wire logic [7:0]        inen_r_in,
  input  wire logic [7:0]        pad_in,
  output var dpg_pad_drive_type  pad_drv,
  output logic [7:0]             read_val,
  output logic [7:0]             pin_level,
  output logic [7:0]             pin_prev,
  output logic                   wake_change
);
  logic [7:0] s1_r, s2_r, prev_r;
  logic [7:0] s1_nxt, s2_nxt, prev_nxt;
  logic [7:0] gated;

  always_comb begin
    // Output drives low always, high only on push-pull pins
    pad_drv.out  = data_r_in;
    pad_drv.oe   = dir_r_in & ~(OPEN_DRAIN & data_r_in);
    // Pull-up off when absent or when driving low
    pad_drv.pull = pull_r_in & HAS_PULL & ~(dir_r_in & ~data_r_in);
    s1_nxt       = pad_in;
    s2_nxt       = s1_r;
    gated        = s2_r & (inen_r_in | ~INPUT_GATED);
    prev_nxt     = gated;
    read_val     = (dir_r_in & data_r_in) | (~dir_r_in & gated);
    pin_level    = gated;
    pin_prev     = prev_r;
    wake_change  = |((gated ^ prev_r) & ~dir_r_in & inen_r_in);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_r   <= DPG_RST_ZERO;
      s2_r   <= DPG_RST_ZERO;
      prev_r <= DPG_RST_ZERO;
    end else begin
      s1_r   <= s1_nxt;
      s2_r   <= s2_nxt;
      prev_r <= prev_nxt;
    end
  end
endmodule : dpg_port
`default_nettype wire

// ==== sim/dpg_board.sv ====
// Board-side model of the pads: external drivers, pull-ups and floating lines
`timescale 1ns/100ps
`default_nettype none
module dpg_board
  import dpg_pkg::*;
(
  input  wire logic              clk,
  input  wire dpg_pad_drive_type pad,
  input  wire logic [7:0]        ext_val,
  input  wire logic [7:0]        ext_en,
  output logic [7:0]             level
);
  logic [7:0] last_r = 8'h00;
  // A released line with no pull shows the inverse of its last driven level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad.oe[i]) level[i] = pad.out[i];
      else if (ext_en[i]) level[i] = ext_val[i];
      else if (pad.pull[i]) level[i] = 1'b1;
      else level[i] = ~last_r[i];
    end
  end
  always_ff @(posedge clk) begin
    for (int i = 0; i < 8; i++) begin
      if (pad.oe[i] | ext_en[i] | pad.pull[i]) last_r[i] <= level[i];
    end
  end
endmodule : dpg_board
`default_nettype wire

// ==== sim/dpg_gpio_test.sv ====
// Self-checking bench for the dual port GPIO block
`timescale 1ns/100ps
`default_nettype none
module dpg_gpio_test;
  import dpg_pkg::*;
  logic              clk, arst_n, sleep_mode, wake_req, a_irq, b_irq;
  dpg_io_req_type    io_req;
  dpg_pad_drive_type port_a_pad, port_b_pad;
  logic [7:0]        io_rdata, a_lvl, b_lvl, a_ext, b_ext;
  int                error_cnt, n_tests, cyc, a_cnt, b_cnt, w_cnt, sa, sb, sw;
  int                exp_irq [4] = '{2, 1, 1, 0};

  dpg_gpio dpg_gpio_inst (.clk(clk), .arst_n(arst_n), .io_req(io_req), .io_rdata(io_rdata),
    .sleep_mode(sleep_mode), .port_a_pad_in(a_lvl), .port_b_pad_in(b_lvl), .port_a_pad(port_a_pad),
    .port_b_pad(port_b_pad), .wake_req(wake_req), .port_a_pin0_irq(a_irq), .port_b_pin0_irq(b_irq));
  dpg_board dpg_board_inst_a (.clk(clk), .pad(port_a_pad), .ext_val(a_ext), .ext_en(8'hff), .level(a_lvl));
  dpg_board dpg_board_inst_b (.clk(clk), .pad(port_b_pad), .ext_val(b_ext), .ext_en(8'hff), .level(b_lvl));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Event counters and hang guard
  always @(posedge clk) begin
    cyc++;
    if (a_irq === 1'b1) a_cnt++;
    if (b_irq === 1'b1) b_cnt++;
    if (wake_req === 1'b1) w_cnt++;
    if (cyc == 5000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    io_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    io_req.wr <= 1'b0;
  endtask : wr
  task automatic rchk(input string nm, input logic [5:0] a, input logic [7:0] exp);
    @(posedge clk);
    io_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    io_req.rd <= 1'b0;
    @(negedge clk);
    chk(nm, io_rdata, exp);
  endtask : rchk
  // Toggle external pad levels, then allow sync and pulse latency
  task automatic toggle(input logic [7:0] am, input logic [7:0] bm);
    @(posedge clk);
    a_ext <= a_ext ^ am;
    b_ext <= b_ext ^ bm;
    repeat (5) @(posedge clk);
  endtask : toggle
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test

  initial begin
    arst_n = 1'b0;
    io_req = '0;
    sleep_mode = 1'b0;
    a_ext = 8'h00;
    b_ext = 8'h00;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("a_oe", port_a_pad.oe, DPG_RST_ZERO);
    chk("b_pull", port_b_pad.pull, DPG_RST_ZERO);
    rchk("a_data", DPG_OFF_A_DATA, DPG_RST_ZERO);
    rchk("a_dir", DPG_OFF_A_DIR, DPG_RST_ZERO);
    rchk("b_pull", DPG_OFF_B_PULL, DPG_RST_ZERO);
    rchk("edge", DPG_OFF_EDGE_SEL, 8'h00);
    rchk("a_inen", DPG_OFF_A_INEN, 8'h00);
    $display("test reset done");
    wr(DPG_OFF_A_PULL, 8'hff);
    wr(DPG_OFF_B_PULL, 8'hff);
    wr(DPG_OFF_A_DIR, 8'hff);
    wr(DPG_OFF_B_DIR, 8'hff);
    wr(DPG_OFF_A_DATA, 8'h7a);
    wr(DPG_OFF_B_DATA, 8'ha5);
    wr(6'h13, 8'hff);
    rchk("unmapped", 6'h13, 8'h00);
    rchk("a_pull", DPG_OFF_A_PULL, 8'hff);
    rchk("b_dir", DPG_OFF_B_DIR, 8'hff);
    rchk("a_out_rd", DPG_OFF_A_DATA, 8'h7a);
    rchk("b_out_rd", DPG_OFF_B_DATA, 8'ha5);
    chk("a_oe", port_a_pad.oe, 8'hdf);
    chk("a_out", port_a_pad.out & 8'hdf, 8'h5a);
    chk("a_pull", port_a_pad.pull, 8'h5a);
    chk("b_pull", port_b_pad.pull, 8'ha5);
    chk("b_out", port_b_pad.out, 8'ha5);
    $display("test output mode done");
    wr(DPG_OFF_A_DIR, 8'h00);
    wr(DPG_OFF_B_DIR, 8'h00);
    toggle(8'h3c, 8'hff);
    rchk("a_in_rd", DPG_OFF_A_DATA, 8'h3c);
    chk("a_in_pull", port_a_pad.pull, 8'hdf);
    wr(DPG_OFF_A_INEN, 8'h33);
    wr(DPG_OFF_B_INEN, 8'h70);
    toggle(8'hc3, 8'h00);
    rchk("a_gated", DPG_OFF_A_DATA, 8'h37);
    rchk("b_gated", DPG_OFF_B_DATA, 8'h70);
    $display("test input gating done");
    wr(DPG_OFF_A_INEN, 8'hff);
    wr(DPG_OFF_B_INEN, 8'hff);
    toggle(8'hff, 8'hff);
    for (int i = 0; i < 4; i++) begin
      wr(DPG_OFF_EDGE_SEL, {4'h0, i[1:0], i[1:0]});
      sa = a_cnt;
      sb = b_cnt;
      toggle(8'h01, 8'h01);
      toggle(8'h01, 8'h01);
      chk("a_irq", 8'(a_cnt - sa), 8'(exp_irq[i]));
      chk("b_irq", 8'(b_cnt - sb), 8'(exp_irq[i]));
    end
    wr(DPG_OFF_EDGE_SEL, 8'h00);
    wr(DPG_OFF_A_INEN, 8'hfe);
    wr(DPG_OFF_B_INEN, 8'hfe);
    sa = a_cnt;
    sb = b_cnt;
    toggle(8'h01, 8'h01);
    toggle(8'h01, 8'h01);
    chk("a_irq_off", 8'(a_cnt - sa), 8'h00);
    chk("b_irq_off", 8'(b_cnt - sb), 8'h00);
    $display("test interrupts done");
    wr(DPG_OFF_A_INEN, 8'hfb);
    wr(DPG_OFF_B_INEN, 8'hef);
    repeat (4) @(posedge clk);
    sleep_mode <= 1'b1;
    repeat (2) @(posedge clk);
    sw = w_cnt;
    toggle(8'h10, 8'h00);
    chk("wake_on", 8'(w_cnt - sw), 8'h01);
    sw = w_cnt;
    toggle(8'h04, 8'h10);
    chk("wake_off", 8'(w_cnt - sw), 8'h00);
    sw = w_cnt;
    toggle(8'h00, 8'h01);
    chk("wake_b", 8'(w_cnt - sw), 8'h01);
    $display("test wake done");
    stop_test();
  end
endmodule : dpg_gpio_test
`default_nettype wire
